// file: hw/ppa_pkg.sv
// shared constants and types for the bridge arbitration block
// assumes one clock for both bus sides (the two bus clocks are synchronous)
package ppa_pkg;

    // requester numbering: externals 0..5, the bridge itself last
    localparam int PPA_NUM_EXT = 6;
    localparam int PPA_NUM_REQ = 7;
    localparam logic [2:0] PPA_OWN_IDX = 3'h6;
    localparam logic [2:0] PPA_LAST_EXT = 3'h5;
    localparam logic [2:0] PPA_FIRST_IDX = 3'h0;

    // start timeout: cycles of grant plus idle bus before the grant is pulled
    localparam int PPA_START_TIMEOUT = 16;
    localparam logic [4:0] PPA_TO_LAST = 5'(PPA_START_TIMEOUT - 1);
    localparam logic [4:0] PPA_TO_ZERO = 5'h00;

    // values driven while parking
    localparam logic [31:0] PPA_PARK_AD = 32'h0000_0000;
    localparam logic [3:0] PPA_PARK_CBE = 4'h0;
    localparam logic PPA_PARK_PAR = 1'b0;

    // default width of the request mask timer
    localparam int PPA_MASK_W = 8;

    // number of buffered secondary clock outputs
    localparam int PPA_NUM_CLKO = 7;

    typedef enum logic [1:0] {
        UP_IDLE,
        UP_REQ,
        UP_START,
        UP_BUSY
    } ppa_up_st_t;

endpackage

// file: hw/ppa_mask_timer.sv
// request mask timer: one shared down-counter masking retried requesters
// assumes retry pulses are one cycle and name an external requester 0..N-1
`timescale 1ns/100ps

module ppa_mask_timer import ppa_pkg::*; #(
    parameter int N = PPA_NUM_EXT,
    parameter int CW = PPA_MASK_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // retry event and programmed length
    input wire logic retry,
    input wire logic [2:0] retry_id,
    input wire logic [CW-1:0] mask_clocks,
    // masked requesters
    output logic [N-1:0] mask
);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic [N-1:0] mask;
    } ppa_mt_state_t;

    ppa_mt_state_t s_r, s_nxt;
    logic [N-1:0] hit;

    assign hit = (retry && (int'(retry_id) < N)) ? N'(1) << retry_id : '0;

    always_comb begin
        s_nxt = s_r;
        if (s_r.cnt != '0) begin
            s_nxt.cnt = s_r.cnt - CW'(1);
            // expiry frees every requester at once
            if (s_r.cnt == CW'(1)) begin
                s_nxt.mask = '0;
            end
        end
        if (retry && mask_clocks != '0) begin
            // a running timer is not reloaded: later victims get the rest
            if (s_r.cnt == '0) begin
                s_nxt.cnt = mask_clocks;
            end
            // a retry in the expiry cycle is dropped: with no clocks left to run,
            // a mask set now would never be released
            if (s_r.cnt != CW'(1)) begin
                s_nxt.mask = s_nxt.mask | hit;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign mask = s_r.mask;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_mask_expiry: assert property ((s_r.cnt == CW'(1)) |=> mask == '0)
        else $error("mask not released at timer expiry");
    a_mask_load: assert property (
        (retry && s_r.cnt == '0 && mask_clocks != '0 && hit != '0)
        |=> (s_r.cnt == $past(mask_clocks) && (mask & $past(hit)) != '0))
        else $error("retry did not start the mask timer");

endmodule

// file: hw/ppa_arbiter.sv
// bridge bus arbitration: upstream requester and downstream central arbiter
// assumes both bus sides share clk; bus pins are split into in, out and enable
`timescale 1ns/100ps

// Overview of operation
// - raise upstream request while a downstream transaction waits to go upstream
// - cycle after grant with idle bus: frame, address, command out, request dropped
// - the upstream request may be withdrawn any time before the start
// - park upstream lines only with grant asserted and own request deasserted
// - strap low enables the internal downstream arbiter, high means external arbiter
// - internal arbiter serves six external request/grant pairs plus the bridge
// - bridge requests downstream only for work on behalf of upstream initiators
// - grants ignore upstream state; non-posted crossings need both buses held
// - each downstream frame assertion reassigns priorities; grant highest asserted request
// - higher-priority request preempts a lower grant on the next clock
// - on a busy bus a grant may move to another in one cycle
// - on an idle bus at least one cycle passes between two grants
// - grant removed after 16 granted idle cycles without frame
// - timed-out initiator waits until it drops its request for a cycle
// - mode low: bridge on top every other arbitration cycle, externals rotate otherwise
// - mode high: top priority rotates over all seven requesters
// - a target retry starts the mask timer and masks that initiator
// - later retried initiators are masked only for the remaining timer clocks
// - arbiter off: grant 0 is own request, request 0 own grant, rest idle
// - arbiter on parks on idle bus with no grant or own grant; off parks only while request 0 asserted
// - both bus sides are driven and sampled on the same synchronous clock
// - seven buffered secondary clock outputs are provided
module ppa_arbiter import ppa_pkg::*; #(
    parameter int MASK_W = PPA_MASK_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration
    input wire logic cfn_n,
    input wire logic arb_rotate,
    input wire logic [MASK_W-1:0] mask_clocks,
    // upstream job from the forwarding logic
    input wire logic up_fwd_req,
    input wire logic [31:0] up_addr,
    input wire logic [3:0] up_cmd,
    input wire logic up_done,
    // upstream bus
    input wire logic up_gnt_n,
    input wire logic up_frame_in_n,
    input wire logic up_irdy_in_n,
    output logic up_req_n,
    output logic up_frame_n_o,
    output logic up_frame_oe,
    output logic [31:0] up_ad_o,
    output logic up_ad_oe,
    output logic [3:0] up_cbe_n_o,
    output logic up_cbe_oe,
    output logic up_par_o,
    output logic up_par_oe,
    // downstream job and retry events
    input wire logic own_fwd_req,
    input wire logic dn_retry,
    input wire logic [2:0] dn_retry_id,
    input wire logic cross_posted,
    output logic own_gnt,
    output logic xfer_go,
    // downstream bus
    input wire logic [5:0] dn_req_n,
    input wire logic dn_frame_n,
    input wire logic dn_irdy_n,
    output logic [5:0] dn_gnt_n,
    output logic [31:0] dn_ad_o,
    output logic dn_ad_oe,
    output logic [3:0] dn_cbe_n_o,
    output logic dn_cbe_oe,
    output logic dn_par_o,
    output logic dn_par_oe,
    // secondary clock fan-out
    output logic [PPA_NUM_CLKO-1:0] sec_clk_o
);

    typedef struct packed {
        ppa_up_st_t up_st;
        logic up_req_n;
        logic up_frame_n;
        logic up_frame_oe;
        logic [31:0] up_ad;
        logic [3:0] up_cbe;
        logic up_ad_oe;
        logic up_par;
        logic up_par_oe;
        logic strap_done;
        logic central_n;
        logic [2:0] top;
        logic alt_own;
        logic [2:0] ext_ptr;
        logic frame_d;
        logic gnt_valid;
        logic [2:0] gnt_idx;
        logic [4:0] to_cnt;
        logic [6:0] lock;
        logic [5:0] gnt_n;
        logic own_gnt;
        logic dn_park;
        logic dn_par_oe;
    } ppa_arb_state_t;

    localparam ppa_arb_state_t RST_STATE = '{
        up_st: UP_IDLE, up_req_n: 1'b1, up_frame_n: 1'b1, up_frame_oe: 1'b0,
        up_ad: PPA_PARK_AD, up_cbe: PPA_PARK_CBE, up_ad_oe: 1'b0, up_par: 1'b0,
        up_par_oe: 1'b0, strap_done: 1'b0, central_n: 1'b1, top: PPA_FIRST_IDX,
        alt_own: 1'b1, ext_ptr: PPA_FIRST_IDX, frame_d: 1'b1, gnt_valid: 1'b0,
        gnt_idx: PPA_FIRST_IDX, to_cnt: PPA_TO_ZERO, lock: 7'h00, gnt_n: 6'h3f,
        own_gnt: 1'b0, dn_park: 1'b0, dn_par_oe: 1'b0};

    ppa_arb_state_t s_r, s_nxt;

    logic up_idle;
    logic dn_idle;
    logic frame_start;
    logic central;
    logic [5:0] mask;
    logic [6:0] req_vec;
    logic [6:0] elig;
    logic [2:0] start_idx;
    logic [3:0] win;
    logic to_fire;
    logic [6:0] to_hit;
    logic [6:0] gvec;

    // first eligible requester in circular order from the top-priority slot
    function automatic logic [3:0] pick(input logic [6:0] el, input logic [2:0] st);
        logic [3:0] r;
        int j;
        r = 4'h0;
        for (int k = PPA_NUM_REQ - 1; k >= 0; k--) begin
            j = (int'(st) + k) % PPA_NUM_REQ;
            if (el[j]) begin
                r = {1'b1, 3'(j)};
            end
        end
        return r;
    endfunction

    ppa_mask_timer #(
        .N(PPA_NUM_EXT),
        .CW(MASK_W)
    ) u_mask (
        .clk(clk),
        .rst_n(rst_n),
        .retry(dn_retry & central),
        .retry_id(dn_retry_id),
        .mask_clocks(mask_clocks),
        .mask(mask)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // bus observation and priority selection

    assign up_idle = up_frame_in_n & up_irdy_in_n;
    assign dn_idle = dn_frame_n & dn_irdy_n;
    assign frame_start = s_r.frame_d & ~dn_frame_n;
    assign central = s_r.strap_done & ~s_r.central_n;
    // the bridge's own request comes only from upstream-initiated work
    assign req_vec = {own_fwd_req, ~dn_req_n};
    assign elig = req_vec & ~s_r.lock & ~{1'b0, mask};
    // alternating mode puts the bridge on top on every other arbitration cycle
    assign start_idx = arb_rotate ? s_r.top
                                  : (s_r.alt_own ? PPA_OWN_IDX : s_r.ext_ptr);
    assign win = pick(elig, start_idx);
    assign to_fire = s_r.gnt_valid & dn_idle & (s_r.to_cnt == PPA_TO_LAST);
    assign to_hit = to_fire ? 7'(1) << s_r.gnt_idx : 7'h00;
    assign gvec = s_r.gnt_valid ? 7'(1) << s_r.gnt_idx : 7'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_nxt = s_r;
        // strap is caught once, in the first cycle after reset release
        if (!s_r.strap_done) begin
            s_nxt.strap_done = 1'b1;
            s_nxt.central_n = cfn_n;
        end

        // upstream requester
        case (s_r.up_st)
            UP_IDLE: begin
                if (up_fwd_req) begin
                    s_nxt.up_st = UP_REQ;
                    s_nxt.up_req_n = 1'b0;
                end
            end
            UP_REQ: begin
                if (!up_fwd_req) begin
                    s_nxt.up_st = UP_IDLE;
                    s_nxt.up_req_n = 1'b1;
                end else if (!up_gnt_n && up_idle) begin
                    s_nxt.up_st = UP_START;
                    s_nxt.up_frame_n = 1'b0;
                    s_nxt.up_frame_oe = 1'b1;
                    s_nxt.up_ad = up_addr;
                    s_nxt.up_cbe = up_cmd;
                    s_nxt.up_req_n = 1'b1;
                end
            end
            UP_START: begin
                s_nxt.up_st = UP_BUSY;
            end
            UP_BUSY: begin
                if (up_done) begin
                    s_nxt.up_st = UP_IDLE;
                    s_nxt.up_frame_n = 1'b1;
                    s_nxt.up_frame_oe = 1'b0;
                end
            end
            default: begin
                s_nxt.up_st = UP_IDLE;
                s_nxt.up_req_n = 1'b1;
                s_nxt.up_frame_n = 1'b1;
                s_nxt.up_frame_oe = 1'b0;
            end
        endcase
        // address phase, or parking when granted with no request of our own
        s_nxt.up_ad_oe = 1'b0;
        if (s_nxt.up_st == UP_START) begin
            s_nxt.up_ad_oe = 1'b1;
        end else if (s_nxt.up_st == UP_IDLE && !up_gnt_n && up_idle) begin
            s_nxt.up_ad_oe = 1'b1;
            s_nxt.up_ad = PPA_PARK_AD;
            s_nxt.up_cbe = PPA_PARK_CBE;
        end
        // parity trails its address/command by one clock
        s_nxt.up_par = ^{s_r.up_ad, s_r.up_cbe};
        s_nxt.up_par_oe = s_r.up_ad_oe;

        // priority reassignment at each new downstream transaction
        s_nxt.frame_d = dn_frame_n;
        if (frame_start) begin
            s_nxt.top = (s_r.top == PPA_OWN_IDX) ? PPA_FIRST_IDX : s_r.top + 3'h1;
            s_nxt.alt_own = ~s_r.alt_own;
            if (!s_r.alt_own) begin
                s_nxt.ext_ptr = (s_r.ext_ptr == PPA_LAST_EXT) ? PPA_FIRST_IDX
                                                              : s_r.ext_ptr + 3'h1;
            end
        end

        // grant sequencing; grants never look at the upstream side
        if (!central) begin
            s_nxt.gnt_valid = 1'b0;
        end else if (to_fire) begin
            s_nxt.gnt_valid = 1'b0;
        end else if (s_r.gnt_valid) begin
            if (!win[3]) begin
                s_nxt.gnt_valid = 1'b0;
            end else if (win[2:0] != s_r.gnt_idx) begin
                if (!dn_idle) begin
                    s_nxt.gnt_idx = win[2:0];
                end else begin
                    // idle bus: drop now, new grant a clock later
                    s_nxt.gnt_valid = 1'b0;
                end
            end
        end else if (win[3]) begin
            s_nxt.gnt_valid = 1'b1;
            s_nxt.gnt_idx = win[2:0];
        end

        // lock is set on timeout and freed by a dropped request; set wins
        s_nxt.lock = (s_r.lock & req_vec) | to_hit;

        // start timeout counter
        if (!s_r.gnt_valid || !s_nxt.gnt_valid || s_nxt.gnt_idx != s_r.gnt_idx
            || frame_start) begin
            s_nxt.to_cnt = PPA_TO_ZERO;
        end else if (dn_idle) begin
            s_nxt.to_cnt = s_r.to_cnt + 5'h01;
        end

        // grant pins, own grant and downstream parking
        if (central) begin
            s_nxt.gnt_n = ~(s_nxt.gnt_valid ? 6'(7'(1) << s_nxt.gnt_idx) : 6'h00);
            s_nxt.own_gnt = s_nxt.gnt_valid && s_nxt.gnt_idx == PPA_OWN_IDX;
            s_nxt.dn_park = dn_idle && (!s_nxt.gnt_valid || s_nxt.gnt_idx == PPA_OWN_IDX);
        end else begin
            // external arbiter: line 0 pair turned round, others quiet
            s_nxt.gnt_n = {5'h1f, ~own_fwd_req};
            s_nxt.own_gnt = own_fwd_req && !dn_req_n[0];
            s_nxt.dn_park = s_r.strap_done && dn_idle && !dn_req_n[0];
        end
        s_nxt.dn_par_oe = s_r.dn_park;
    end

    // both bus sides share this clock; one register bank
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= RST_STATE;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign up_req_n = s_r.up_req_n;
    assign up_frame_n_o = s_r.up_frame_n;
    assign up_frame_oe = s_r.up_frame_oe;
    assign up_ad_o = s_r.up_ad;
    assign up_ad_oe = s_r.up_ad_oe;
    assign up_cbe_n_o = s_r.up_cbe;
    assign up_cbe_oe = s_r.up_ad_oe;
    assign up_par_o = s_r.up_par;
    assign up_par_oe = s_r.up_par_oe;
    assign own_gnt = s_r.own_gnt;
    // data phases of a non-posted crossing wait for both buses
    assign xfer_go = cross_posted
                     | (s_r.own_gnt & (s_r.up_st == UP_START || s_r.up_st == UP_BUSY));
    assign dn_gnt_n = s_r.gnt_n;
    assign dn_ad_o = PPA_PARK_AD;
    assign dn_ad_oe = s_r.dn_park;
    assign dn_cbe_n_o = PPA_PARK_CBE;
    assign dn_cbe_oe = s_r.dn_park;
    assign dn_par_o = PPA_PARK_PAR;
    assign dn_par_oe = s_r.dn_par_oe;
    // buffered copies of the secondary clock; one may feed back to the clock input
    assign sec_clk_o = {PPA_NUM_CLKO{clk}};

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_up_request: assert property ((s_r.up_st == UP_IDLE && up_fwd_req) |=> !up_req_n)
        else $error("upstream request not raised");
    a_up_start: assert property (
        (s_r.up_st == UP_REQ && up_fwd_req && !up_gnt_n && up_idle)
        |=> (!up_frame_n_o && up_req_n && up_ad_o == $past(up_addr)
             && up_cbe_n_o == $past(up_cmd)))
        else $error("upstream start not one cycle after grant");
    a_up_park: assert property (
        (up_ad_oe && up_frame_n_o) |-> (!$past(up_gnt_n) && up_req_n))
        else $error("upstream parked without grant");
    a_strap_held: assert property (
        ($past(s_r.strap_done) && s_r.strap_done) |-> $stable(central))
        else $error("arbiter enable moved after reset");
    a_ext_quiet: assert property (
        (s_r.strap_done && s_r.central_n) |=> dn_gnt_n[5:1] == 5'h1f)
        else $error("grants 5:1 active with arbiter off");
    a_idle_gap: assert property (
        ($past(dn_idle) && $past(gvec) != 7'h00 && gvec != $past(gvec))
        |-> gvec == 7'h00)
        else $error("grant moved on idle bus without gap");
    a_start_tmo: assert property (
        (central && s_r.gnt_valid && dn_idle && s_r.to_cnt == PPA_TO_LAST)
        |=> (gvec == 7'h00
             && s_r.lock == (($past(s_r.lock) & $past(req_vec)) | $past(to_hit))))
        else $error("start timeout did not remove grant");
    a_lock_block: assert property ((gvec & ~$past(gvec) & $past(s_r.lock)) == 7'h00)
        else $error("timed-out initiator granted again");
    a_mask_block: assert property ((gvec[5:0] & ~$past(gvec[5:0]) & $past(mask)) == 6'h00)
        else $error("masked initiator granted");

    c_up_start: cover property (s_r.up_st == UP_REQ ##1 s_r.up_st == UP_START);
    c_timeout: cover property (to_fire);
    c_busy_swap: cover property (gvec != 7'h00 ##1 (gvec != 7'h00 && gvec != $past(gvec)));
    c_retry_mask: cover property (mask != 6'h00 ##[1:20] dn_gnt_n != 6'h3f);

endmodule

// file: sim/ppa_far_model.sv
// far side of the arbitration block: upstream arbiter and six downstream masters
// assumes the bench commands which masters want the bus and whether they start frames
`timescale 1ns/100ps

module ppa_far_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // bench commands
    input wire logic [5:0] want,
    input wire logic go,
    input wire logic up_stall,
    input wire logic up_park,
    // upstream arbiter
    input wire logic up_req_n,
    output logic up_gnt_n,
    // downstream masters
    input wire logic [5:0] dn_gnt_n,
    output logic [5:0] dn_req_n,
    output logic dn_frame_n,
    output logic dn_irdy_n
);
    ////////////////////////////////////////////////////////////////////////////
    // phase 1 address, 2 data, 3 last data; frame and irdy idle high by pull-up
    logic [1:0] ph_r;

    assign dn_req_n = ~want;
    assign dn_frame_n = ~(ph_r == 2'h1 || ph_r == 2'h2);
    assign dn_irdy_n = ~(ph_r == 2'h2 || ph_r == 2'h3);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            up_gnt_n <= 1'b1;
            ph_r <= 2'h0;
        end else begin
            // stall keeps the grant back to show a slow arbiter
            up_gnt_n <= ~((~up_req_n & ~up_stall) | up_park);
            if (ph_r != 2'h0) begin
                ph_r <= ph_r + 2'h1;
            end else if (go && dn_frame_n && dn_irdy_n && |(~dn_gnt_n & want)) begin
                ph_r <= 2'h1;
            end
        end
    end
endmodule

// file: sim/tb_top.sv
// self-checking bench for the bridge arbitration block
// assumes ppa_pkg, ppa_arbiter and the far-side model ppa_far_model
`timescale 1ns/100ps

module tb_top import ppa_pkg::*;;
    logic clk = 1'b0, rst_n = 1'b0, cfn_n = 1'b0, arb_rotate = 1'b0, up_fwd_req = 1'b0;
    logic up_done = 1'b0, own_fwd_req = 1'b0, dn_retry = 1'b0, cross_posted = 1'b0;
    logic go = 1'b0, up_stall = 1'b0, up_park = 1'b0, idle_q = 1'b1;
    logic [7:0] mask_clocks = 8'h28;
    logic [31:0] up_addr = 32'h0, seed = 32'h0000c94e;
    logic [3:0] up_cmd = 4'h0;
    logic [2:0] dn_retry_id = 3'h0;
    logic [5:0] want = 6'h00, g_q = 6'h3f;
    logic up_gnt_n, up_frame_in_n, up_irdy_in_n, up_req_n, up_frame_n_o, up_frame_oe;
    logic up_ad_oe, up_cbe_oe, up_par_o, up_par_oe, own_gnt, xfer_go, dn_frame_n, dn_irdy_n;
    logic dn_ad_oe, dn_cbe_oe, dn_par_o, dn_par_oe;
    logic [31:0] up_ad_o, dn_ad_o;
    logic [3:0] up_cbe_n_o, dn_cbe_n_o;
    logic [5:0] dn_req_n, dn_gnt_n;
    logic [6:0] sec_clk_o;
    int num_errors = 0, cmp_count = 0, n;

    // upstream frame wire: pulled up unless the bridge drives it
    assign up_frame_in_n = up_frame_oe ? up_frame_n_o : 1'b1;
    assign up_irdy_in_n = 1'b1;

    always #10 clk = ~clk;

    ppa_arbiter DUT (.clk(clk), .rst_n(rst_n), .cfn_n(cfn_n), .arb_rotate(arb_rotate),
        .mask_clocks(mask_clocks), .up_fwd_req(up_fwd_req), .up_addr(up_addr),
        .up_cmd(up_cmd), .up_done(up_done), .up_gnt_n(up_gnt_n),
        .up_frame_in_n(up_frame_in_n), .up_irdy_in_n(up_irdy_in_n), .up_req_n(up_req_n),
        .up_frame_n_o(up_frame_n_o), .up_frame_oe(up_frame_oe), .up_ad_o(up_ad_o),
        .up_ad_oe(up_ad_oe), .up_cbe_n_o(up_cbe_n_o), .up_cbe_oe(up_cbe_oe),
        .up_par_o(up_par_o), .up_par_oe(up_par_oe), .own_fwd_req(own_fwd_req),
        .dn_retry(dn_retry), .dn_retry_id(dn_retry_id), .cross_posted(cross_posted),
        .own_gnt(own_gnt), .xfer_go(xfer_go), .dn_req_n(dn_req_n), .dn_frame_n(dn_frame_n),
        .dn_irdy_n(dn_irdy_n), .dn_gnt_n(dn_gnt_n), .dn_ad_o(dn_ad_o), .dn_ad_oe(dn_ad_oe),
        .dn_cbe_n_o(dn_cbe_n_o), .dn_cbe_oe(dn_cbe_oe), .dn_par_o(dn_par_o),
        .dn_par_oe(dn_par_oe), .sec_clk_o(sec_clk_o));

    ppa_far_model far (.clk(clk), .rst_n(rst_n), .want(want), .go(go), .up_stall(up_stall),
        .up_park(up_park), .up_req_n(up_req_n), .up_gnt_n(up_gnt_n), .dn_gnt_n(dn_gnt_n),
        .dn_req_n(dn_req_n), .dn_frame_n(dn_frame_n), .dn_irdy_n(dn_irdy_n));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask

    task automatic complete_run();
        if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic do_reset(input logic cfn);
        rst_n = 1'b0;
        cfn_n = cfn;
        want = 6'h00;
        step(20);
        rst_n = 1'b1;
        step(5);
    endtask

    task automatic wait_gnt(input int k, input int lim, output int cnt);
        cnt = 0;
        while (dn_gnt_n[k] !== 1'b0 && cnt < lim) begin
            step(1);
            cnt++;
        end
    endtask

    // second retry is issued gap cycles after the first; want is raised once mask is set
    task automatic mask_trial(input int a, input int b, input int gap);
        int cnt;
        dn_retry_id = 3'(a);
        dn_retry = 1'b1;
        step(1);
        dn_retry = 1'b0;
        if (gap > 0) begin
            step(gap - 1);
            dn_retry_id = 3'(b);
            dn_retry = 1'b1;
            step(1);
            dn_retry = 1'b0;
        end
        step(1);
        want[b] = 1'b1;
        wait_gnt(b, 80, cnt);
        chk(cnt + gap + 1, mask_clocks + 1);
        go = 1'b1;
        step(1);
        want = 6'h00;
        go = 1'b0;
        step(6);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // idle-bus grant handover and single-grant watch
    always @(negedge clk) begin
        if (rst_n && !cfn_n) begin
            if (idle_q && g_q != 6'h3f && dn_gnt_n != 6'h3f) chk(dn_gnt_n, g_q);
            chk($countones(~dn_gnt_n) < 2, 1'b1);
            g_q = dn_gnt_n;
            idle_q = dn_frame_n & dn_irdy_n;
        end
    end

    initial begin
        #400000;
        num_errors++;
        complete_run();
    end

    initial begin
        int k, b;
        logic [5:0] seen;
        do_reset(1'b0);
        chk({up_req_n, dn_gnt_n, up_frame_oe}, {1'b1, 6'h3f, 1'b0});
        chk(sec_clk_o, {7{clk}});
        chk({dn_ad_oe, dn_cbe_oe, dn_par_oe, dn_par_o, dn_ad_o, dn_cbe_n_o}, {3'b111, 37'h0});
        for (int i = 0; i < 3; i++) begin
            up_addr = rnd();
            up_cmd = 4'(rnd());
            up_stall = 1'(rnd());
            up_fwd_req = 1'b1;
            step(1);
            chk(up_req_n, 1'b0);
            n = 0;
            while (up_frame_oe !== 1'b1 && n < 10) begin
                if (n == 3) up_stall = 1'b0;
                step(1);
                n++;
            end
            chk({up_frame_n_o, up_req_n, up_ad_oe, up_cbe_n_o, up_ad_o},
                {3'b011, up_cmd, up_addr});
            up_fwd_req = 1'b0;
            step(1);
            chk({up_ad_oe, up_par_oe, up_frame_oe, up_par_o}, {3'b011, ^{up_addr, up_cmd}});
            up_done = 1'b1;
            step(1);
            up_done = 1'b0;
            step(2);
            chk(up_frame_oe, 1'b0);
        end
        up_stall = 1'b1;
        up_fwd_req = 1'b1;
        step(2);
        up_fwd_req = 1'b0;
        step(2);
        chk({up_req_n, up_frame_oe}, 2'b10);
        up_stall = 1'b0;
        up_park = 1'b1;
        step(3);
        chk({up_ad_oe, up_cbe_oe, up_frame_oe, up_ad_o, up_cbe_n_o}, {3'b110, 36'h0});
        up_park = 1'b0;
        step(3);
        chk(up_ad_oe, 1'b0);
        // start timeout, then lock until the request is dropped for a cycle
        k = rnd() % 6;
        want[k] = 1'b1;
        wait_gnt(k, 10, n);
        n = 0;
        while (dn_gnt_n[k] === 1'b0 && n < 40) begin
            step(1);
            n++;
        end
        chk(n, PPA_START_TIMEOUT);
        step(8);
        chk(dn_gnt_n[k], 1'b1);
        want[k] = 1'b0;
        step(1);
        want[k] = 1'b1;
        wait_gnt(k, 10, n);
        chk(dn_gnt_n[k], 1'b0);
        go = 1'b1;
        step(1);
        want = 6'h00;
        go = 1'b0;
        step(6);
        own_fwd_req = 1'b1;
        n = 0;
        while (own_gnt !== 1'b1 && n < 20) begin
            step(1);
            n++;
        end
        chk({own_gnt, dn_gnt_n, xfer_go}, {1'b1, 6'h3f, 1'b0});
        cross_posted = 1'b1;
        step(1);
        chk(xfer_go, 1'b1);
        cross_posted = 1'b0;
        own_fwd_req = 1'b0;
        step(3);
        chk(own_gnt, 1'b0);
        k = rnd() % 6;
        b = (k + 1 + rnd() % 5) % 6;
        mask_trial(k, k, 0);
        mask_trial(k, b, 12);
        for (int m = 0; m < 2; m++) begin
            arb_rotate = m[0];
            want = 6'h3f;
            go = 1'b1;
            seen = 6'h00;
            repeat (70) begin
                step(1);
                seen = seen | ~dn_gnt_n;
            end
            chk(seen, 6'h3f);
            want = 6'h00;
            step(6);
        end
        // random traffic with the handover watch running
        repeat (40) begin
            want = 6'(rnd());
            go = 1'(rnd());
            arb_rotate = 1'(rnd());
            step(1 + rnd() % 4);
        end
        want = 6'h00;
        go = 1'b0;
        step(8);
        do_reset(1'b1);
        want = 6'h3f;
        step(4);
        chk(dn_gnt_n, 6'h3f);
        own_fwd_req = 1'b1;
        step(3);
        chk({dn_gnt_n, own_gnt, dn_ad_oe}, {6'h3e, 2'b11});
        want = 6'h00;
        own_fwd_req = 1'b0;
        step(3);
        chk({dn_gnt_n, own_gnt, dn_ad_oe}, {6'h3f, 2'b00});
        complete_run();
    end
endmodule
